// >>> upstream_framer_pkg.sv
package upstream_framer_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SR_PREP_NS      = 900;
  localparam int unsigned MR_PREP_NS      = 1800;
  // Longest times round down to whole cycles
  localparam logic [9:0]  SR_PREP_CYC     = 10'(SR_PREP_NS * CLK_MHZ / 1000);
  localparam logic [9:0]  MR_PREP_CYC     = 10'(MR_PREP_NS * CLK_MHZ / 1000);
  localparam logic [2:0]  PREP_DS_EDGES   = 3'h4;
  localparam int unsigned UP_RSP_TIME_US  = 100;
  localparam int unsigned UP_RSP_CYC      = UP_RSP_TIME_US * CLK_MHZ;
  localparam int unsigned DATA_TMO_MIN_US = 60;
  localparam int unsigned DATA_TMO_MAX_US = 135;
  localparam int unsigned DATA_TMO_CYC    = DATA_TMO_MIN_US * CLK_MHZ;

  // ==========================================================
  // Register map and fields
  localparam logic [3:0]  CFG_OFS        = 4'h0;
  localparam logic [3:0]  CMD_OFS        = 4'h4;
  localparam logic [3:0]  STAT_OFS       = 4'h8;
  localparam logic [3:0]  DIAG_OFS       = 4'hC;
  localparam int unsigned CFG_FMT16_BIT  = 0;
  localparam int unsigned CFG_DIV_LSB    = 1;
  localparam int unsigned CFG_FIXA_BIT   = 4;
  localparam int unsigned CFG_ADDR_LSB   = 8;
  localparam int unsigned CMD_STOP_BIT   = 0;
  localparam logic [7:0]  DIV_BASE       = 8'h02;

  // ==========================================================
  // Frame lengths
  localparam logic [4:0]  LEN12          = 5'h0C;
  localparam logic [4:0]  LEN16          = 5'h10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {UP_IDLE, UP_PREP, UP_SEND} up_state_t;

  typedef struct packed {
    logic       upstream_frame_format;
    logic [2:0] upstream_divider_select;
    logic       fix_mode;
    logic [3:0] fixed_address_value;
  } cfg_t;

  typedef struct packed {
    logic       stb;
    logic       multi;
    logic [3:0] count;
  } rd_cmd_t;

  typedef struct packed {
    logic [7:0] cnt;
  } tick_st_t;

  typedef struct packed {
    logic        ap_v;
    logic        ap_w;
    logic [3:0]  ap_a;
    cfg_t        cfg;
    logic        tmo_flag;
    logic [15:0] tmo_cnt;
    logic        kill;
    logic        wr_exec;
    logic        data_exec;
    logic        ds_q;
    up_state_t   st;
    logic [9:0]  prep_cnt;
    logic [2:0]  prep_edges;
    logic [3:0]  remain;
    logic [3:0]  idx;
    logic [3:0]  addr_lat;
    logic        ovf;
    logic [15:0] sh;
    logic [4:0]  bits_left;
    logic        sdo;
  } ctl_st_t;

endpackage

// >>> up_frame_build.sv
module up_frame_build (
  input  wire logic       fmt16,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] data,
  output logic      [15:0] frame,
  output logic      [4:0]  len
);
  import upstream_framer_pkg::*;

  logic par;

  // ==========================================================
  // Frame assembly, start bit first in bit 0
  always_comb
  begin
    par = ^data;
    if (fmt16)
    begin
      frame = {2'b11, par, data, addr, 1'b0};
      len   = LEN16;
    end
    else
    begin
      // Top nibble unused, filled high so a stray shift stays idle
      frame = {4'hF, 2'b11, par, data, 1'b0};
      len   = LEN12;
    end
  end

endmodule

// >>> up_bit_tick.sv
module up_bit_tick (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ds_rise,
  input  wire logic [2:0] div_sel,
  input  wire logic       run,
  output logic            tick
);
  import upstream_framer_pkg::*;

  tick_st_t   s_r;
  tick_st_t   s_nxt;
  logic [7:0] limit;

  // ==========================================================
  // Divide downstream clock edges into bit periods
  always_comb
  begin
    limit = (DIV_BASE << div_sel) - 8'h01;
    tick  = run && ds_rise && (s_r.cnt == limit);
    s_nxt = s_r;
    if (!run || tick)
      s_nxt.cnt = 8'h00;
    else if (ds_rise)
      s_nxt.cnt = s_r.cnt + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule

// >>> upstream_readback_framer.sv
//
// Summary of operation
// - Ignored read during transfer sets flag bit zero
// - Bit one high while further frames pending
// - 12-bit frame: start, data, parity, stops
// - 16-bit frame: start, address, data, parity, stops
// - Parity makes data plus parity even
// - Transmission starts within 100 us response
// - Reads during transfer are discarded
// - New read only after final stop bit
// - Data frames always executed
// - Writes dropped during preparation time
// - Writes executed after preparation, even sending
// - Transmitted value captured before later writes
// - Stop command aborts and clears pending reads
// - Response measured select rise to start bit
// - Flag timeout without valid data frame
// - Format field selects 12 or 16 bits
// - Bit rate divided from downstream clock
// - Timeout kills outputs; diag read clears flag
//
module upstream_readback_framer #(
  parameter int unsigned RSP_CYC = upstream_framer_pkg::UP_RSP_CYC,
  parameter int unsigned TMO_CYC = upstream_framer_pkg::DATA_TMO_CYC
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          ds_clk,
  input  wire upstream_framer_pkg::rd_cmd_t  rd_cmd,
  output logic      [3:0]                    rd_index,
  input  wire logic [7:0]                    rd_value,
  input  wire logic                          wr_cmd_stb,
  output logic                               wr_exec,
  input  wire logic                          data_frame_stb,
  output logic                               data_exec,
  output logic                               out_kill,
  output logic                               sdo
);
  import upstream_framer_pkg::*;

  ctl_st_t     s;
  ctl_st_t     n;
  logic        ds_rise;
  logic        tick;
  logic        wr_go;
  logic        rd_go;
  logic        stop;
  logic [3:0]  f_idx;
  logic [3:0]  f_rem;
  logic [3:0]  f_addr;
  logic [15:0] f_frame;
  logic [4:0]  f_len;
  logic [16:0] rsp_cnt_r;

  // ==========================================================
  // Bus decode, always zero wait and OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_go     = s.ap_v && s.ap_w;
  assign rd_go     = s.ap_v && !s.ap_w;
  assign stop      = wr_go && (s.ap_a == CMD_OFS) && hwdata[CMD_STOP_BIT];
  assign ds_rise   = ds_clk && !s.ds_q;

  // Read mux of registered state
  always_comb
  begin
    unique case (s.ap_a)
      CFG_OFS:  hrdata = {20'h00000, s.cfg.fixed_address_value, 3'h0,
                          s.cfg.fix_mode, s.cfg.upstream_divider_select,
                          s.cfg.upstream_frame_format};
      STAT_OFS: hrdata = {24'h000000, s.remain, s.ovf, (s.remain != 4'h0),
                          (s.st == UP_SEND), (s.st == UP_PREP)};
      DIAG_OFS: hrdata = {31'h00000000, s.tmo_flag};
      default:  hrdata = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Next frame content: on a chained frame the index moves on
  assign f_idx    = (s.st == UP_SEND) ? s.idx + 4'h1 : s.idx;
  assign f_rem    = (s.st == UP_SEND) ? s.remain - 4'h1 : s.remain;
  assign rd_index = f_idx;

  // Address nibble: fixed value or overflow/pending/index
  assign f_addr = s.cfg.fix_mode ? s.addr_lat
                : {f_idx[1:0], (f_rem != 4'h0), s.ovf};

  up_frame_build u_build (
    .fmt16 (s.cfg.upstream_frame_format),
    .addr  (f_addr),
    .data  (rd_value),
    .frame (f_frame),
    .len   (f_len)
  );

  up_bit_tick u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ds_rise (ds_rise),
    .div_sel (s.cfg.upstream_divider_select),
    .run     (s.st == UP_SEND),
    .tick    (tick)
  );

  // ==========================================================
  // Control next state
  always_comb
  begin
    n           = s;
    n.wr_exec   = 1'b0;
    n.data_exec = 1'b0;
    n.kill      = 1'b0;
    n.ds_q      = ds_clk;
    n.ap_v      = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      n.ap_w = hwrite;
      n.ap_a = haddr[3:0];
    end

    // Configuration write
    if (wr_go && (s.ap_a == CFG_OFS))
    begin
      n.cfg.upstream_frame_format   = hwdata[CFG_FMT16_BIT];
      n.cfg.upstream_divider_select = hwdata[CFG_DIV_LSB +: 3];
      n.cfg.fix_mode                = hwdata[CFG_FIXA_BIT];
      n.cfg.fixed_address_value     = hwdata[CFG_ADDR_LSB +: 4];
    end

    // Diag read clears first so a same-cycle timeout wins
    if (rd_go && (s.ap_a == DIAG_OFS))
      n.tmo_flag = 1'b0;

    // Data frame supervision
    if (data_frame_stb)
    begin
      n.data_exec = 1'b1;
      n.tmo_cnt   = 16'h0000;
    end
    else if (s.tmo_cnt == 16'(TMO_CYC - 1))
    begin
      n.tmo_cnt  = 16'h0000;
      n.tmo_flag = 1'b1;
      n.kill     = 1'b1;
    end
    else
      n.tmo_cnt = s.tmo_cnt + 16'h0001;

    // Writes are blocked only while preparing
    n.wr_exec = wr_cmd_stb && (s.st != UP_PREP);

    // Read command arbitration
    if (rd_cmd.stb)
    begin
      if (s.st == UP_IDLE)
      begin
        n.st         = UP_PREP;
        n.prep_cnt   = rd_cmd.multi ? MR_PREP_CYC : SR_PREP_CYC;
        n.prep_edges = 3'h0;
        n.remain     = (rd_cmd.multi && rd_cmd.count != 4'h0) ?
                       rd_cmd.count - 4'h1 : 4'h0;
        n.idx        = 4'h0;
        n.addr_lat   = s.cfg.fixed_address_value;
        n.ovf        = 1'b0;
      end
      else
        n.ovf = 1'b1;
    end

    unique case (s.st)
      UP_IDLE:
        n.sdo = 1'b1;
      UP_PREP:
      begin
        n.sdo = 1'b1;
        if (s.prep_cnt != 10'h000)
          n.prep_cnt = s.prep_cnt - 10'h001;
        if (ds_rise && (s.prep_edges != PREP_DS_EDGES))
          n.prep_edges = s.prep_edges + 3'h1;
        // Preparation over: start bit goes out at once
        if ((s.prep_cnt == 10'h000) && (s.prep_edges == PREP_DS_EDGES))
        begin
          n.sh        = f_frame;
          n.bits_left = f_len;
          n.sdo       = f_frame[0];
          n.st        = UP_SEND;
        end
      end
      UP_SEND:
      begin
        if (tick)
        begin
          if (s.bits_left == 5'h01)
          begin
            if (s.remain != 4'h0)
            begin
              n.remain    = f_rem;
              n.idx       = f_idx;
              n.sh        = f_frame;
              n.bits_left = f_len;
              n.sdo       = f_frame[0];
            end
            else
            begin
              n.st  = UP_IDLE;
              n.sdo = 1'b1;
            end
          end
          else
          begin
            n.sh        = {1'b1, s.sh[15:1]};
            n.sdo       = s.sh[1];
            n.bits_left = s.bits_left - 5'h01;
          end
        end
      end
    endcase

    // Stop overrides everything on the upstream side
    if (stop)
    begin
      n.st     = UP_IDLE;
      n.sdo    = 1'b1;
      n.remain = 4'h0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s     <= '0;
      s.st  <= UP_IDLE;
      s.sdo <= 1'b1;
    end
    else
      s <= n;
  end

  assign wr_exec   = s.wr_exec;
  assign data_exec = s.data_exec;
  assign out_kill  = s.kill;
  assign sdo       = s.sdo;

  // ==========================================================
  // Checks
  // Preparation length helper for the response bound
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rsp_cnt_r <= 17'h00000;
    else if (s.st == UP_PREP)
      rsp_cnt_r <= rsp_cnt_r + 17'h00001;
    else
      rsp_cnt_r <= 17'h00000;
  end

  a_resp_time_bound: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rsp_cnt_r < 17'(RSP_CYC))
    else $error("upstream response time exceeded");

  a_idle_line_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s.st != UP_SEND) |-> sdo)
    else $error("serial output low while idle");

  a_start_bit_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(s.st == UP_SEND) |-> !sdo && s.sh[0] == 1'b0)
    else $error("frame did not open with start bit");

  a_parity_even: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(s.st == UP_SEND) |->
      (s.cfg.upstream_frame_format ? ^s.sh[13:5] : ^s.sh[9:1]) == 1'b0)
    else $error("odd parity in upstream frame");

  a_stop_bits_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(s.st == UP_SEND) && !s.cfg.upstream_frame_format |->
      s.sh[11:10] == 2'b11 && s.bits_left == LEN12)
    else $error("bad 12-bit frame tail");

  a_busy_read_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cmd.stb && (s.st != UP_IDLE) && !stop |=>
      s.ovf && (s.st != UP_PREP ||
                ($past(s.st) == UP_PREP && s.prep_cnt <= $past(s.prep_cnt))))
    else $error("read during transfer not ignored");

  a_idle_read_accept: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cmd.stb && (s.st == UP_IDLE) && !stop |=> (s.st == UP_PREP) && !s.ovf)
    else $error("read while idle not accepted");

  a_bit_hold_steady: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s.st == UP_SEND) && !tick && !stop |=> $stable(sdo))
    else $error("serial output moved between bit ticks");

  a_prep_write_block: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd_stb && (s.st == UP_PREP) |=> !wr_exec)
    else $error("write executed during preparation");

  a_send_write_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_cmd_stb && (s.st == UP_SEND) |=> wr_exec)
    else $error("write dropped after preparation");

  a_data_frame_exec: assert property (
    @(posedge hclk) disable iff (!hresetn)
    data_frame_stb |=> data_exec && s.tmo_cnt == 16'h0000)
    else $error("data frame not executed");

  a_timeout_kill: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !data_frame_stb && s.tmo_cnt == 16'(TMO_CYC - 1) |=> out_kill && s.tmo_flag)
    else $error("timeout did not kill outputs");

  a_stop_abort: assert property (
    @(posedge hclk) disable iff (!hresetn)
    stop |=> s.st == UP_IDLE && sdo && s.remain == 4'h0)
    else $error("stop did not abort upstream");

endmodule

// >>> ds_link_model.sv
module ds_link_model (
  input  wire logic       hclk,
  input  wire logic       run,
  input  wire logic [3:0] rd_index,
  output logic            ds_clk,
  output logic [7:0]      rd_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [16];
  int         ph;
  // ==========================================
  // Link clock: 80 ns period, still while idle
  initial
  begin
    ds_clk = 1'b0;
    ph = 0;
  end
  always @(posedge hclk)
  begin
    if (run)
    begin
      ph = (ph == 9) ? 0 : ph + 1;
      if (ph == 0)
        ds_clk <= ~ds_clk;
    end
  end
  // Register values offered to the read port
  assign rd_value = regs[rd_index];
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import upstream_framer_pkg::*;
  localparam int RSP = 1000;
  localparam int TMO = 200;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, (a), (e)); end end
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ds_clk, run;
  logic        wr_cmd_stb, wr_exec, data_frame_stb, data_exec, out_kill, sdo;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  rd_index, fa;
  logic [7:0]  rd_value, d;
  logic [7:0]  sv [3];
  logic        cb [64];
  rd_cmd_t     rd_cmd;
  int          bad_count, checks_done, per, started, i, k, n, resp, seed;

  upstream_readback_framer #(.RSP_CYC(RSP), .TMO_CYC(TMO)) upstream_readback_framer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ds_clk(ds_clk),
    .rd_cmd(rd_cmd), .rd_index(rd_index), .rd_value(rd_value), .wr_cmd_stb(wr_cmd_stb),
    .wr_exec(wr_exec), .data_frame_stb(data_frame_stb), .data_exec(data_exec),
    .out_kill(out_kill), .sdo(sdo));
  ds_link_model ds_link_model_i (.hclk(hclk), .run(run), .rd_index(rd_index),
    .ds_clk(ds_clk), .rd_value(rd_value));

  // ==========================================
  // Verdict and bounded waits
  task tally_and_finish;
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task fail_wait;
    $display("MISMATCH %0t wait limit", $time);
    bad_count++;
    tally_and_finish();
  endtask
  // Bounded wait for hready high at a rising edge
  task rdy;
    int t;
    t = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      t++;
      if (t > 100)
        fail_wait();
      @(posedge hclk);
    end
  endtask
  // ==========================================
  // Bus and strobe drivers
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy();
    q = hrdata;
  endtask
  task cfg(input logic f, input logic [2:0] s, input logic x, input logic [3:0] a);
    bus(1'b1, 32'(CFG_OFS), {20'h0, a, 3'h0, x, s, f});
    per = 40 << s;
  endtask
  // One-cycle strobes, always two or more idle cycles apart
  task pulse_rd(input logic m, input logic [3:0] c);
    @(posedge hclk);
    rd_cmd <= '{1'b1, m, c};
    @(posedge hclk);
    rd_cmd <= '0;
    @(posedge hclk);
  endtask
  task stb_try(input logic df, input logic e);
    @(posedge hclk);
    if (df)
      data_frame_stb <= 1'b1;
    else
      wr_cmd_stb <= 1'b1;
    @(posedge hclk);
    data_frame_stb <= 1'b0;
    wr_cmd_stb <= 1'b0;
    @(negedge hclk);
    `CHK(df ? data_exec : wr_exec, e)
    @(posedge hclk);
  endtask
  // ==========================================
  // Serial capture, sampled mid-bit
  task cap(input int nb);
    resp = 0;
    @(negedge hclk);
    while (sdo !== 1'b0)
    begin
      @(negedge hclk);
      resp++;
      if (resp > RSP + 100)
        fail_wait();
    end
    started = 1;
    repeat (per / 2) @(negedge hclk);
    for (n = 0; n < nb; n++)
    begin
      cb[n] = sdo;
      if (n < nb - 1)
        repeat (per) @(negedge hclk);
    end
  endtask
  task chk_frame(input int b, input logic f, input logic [3:0] a, input logic [7:0] dv);
    logic [15:0] e;
    int          j;
    e = f ? {2'b11, ^dv, dv, a, 1'b0} : {4'h0, 2'b11, ^dv, dv, 1'b0};
    for (j = 0; j < (f ? 16 : 12); j++)
      `CHK(cb[b + j], e[j])
  endtask
  task idle(input int c);
    logic ok;
    ok = 1'b1;
    repeat (c)
    begin
      @(negedge hclk);
      ok &= sdo;
    end
    `CHK(ok, 1'b1)
  endtask

  always #2 hclk = ~hclk;

  // ==========================================
  // Main sequence
  initial
  begin
    {hclk, hresetn, hsel, hwrite, run, wr_cmd_stb, data_frame_stb} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    rd_cmd = '0;
    {bad_count, checks_done, started} = '0;
    per = 40;
    seed = 32'h1a6a9391;
    for (i = 0; i < 16; i++)
      ds_link_model_i.regs[i] = 8'($random(seed));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, then a misaligned offset
    for (i = 0; i < 5; i++)
    begin
      bus(1'b0, (i == 4) ? 32'h2 : 32'(i * 4), 32'h0);
      `CHK(q, 32'h0)
      `CHK(hresp, 1'b0)
    end
    idle(4);
    // Single reads over both formats and two dividers
    run <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      cfg(k[0], {2'b0, k[1]}, 1'b0, 4'h0);
      d = 8'($random(seed));
      ds_link_model_i.regs[0] = d;
      pulse_rd(1'b0, 4'($random(seed)) & 4'h1);
      stb_try(1'b0, 1'b0);
      cap(k[0] ? 16 : 12);
      `CHK(resp < RSP, 1'b1)
      chk_frame(0, k[0], 4'h0, d);
      idle(per);
    end
    // Multi read with stray read, write, data frame and a register change
    cfg(1'b1, 3'h0, 1'b0, 4'h0);
    for (i = 0; i < 3; i++)
      sv[i] = ds_link_model_i.regs[i];
    started = 0;
    pulse_rd(1'b1, 4'h3);
    fork
      cap(48);
      begin
        wait (started == 1);
        repeat (8) @(posedge hclk);
        ds_link_model_i.regs[0] = ~sv[0];
        pulse_rd(1'b0, 4'h0);
        stb_try(1'b0, 1'b1);
        stb_try(1'b1, 1'b1);
      end
    join
    for (i = 0; i < 3; i++)
      chk_frame(i * 16, 1'b1, {2'(i), 1'(i < 2), 1'(i > 0)}, sv[i]);
    idle(600);
    d = ds_link_model_i.regs[0];
    pulse_rd(1'b0, 4'h1);
    cap(16);
    chk_frame(0, 1'b1, 4'h0, d);
    idle(per);
    // Fixed address held across a multi read
    fa = 4'($random(seed));
    cfg(1'b1, 3'h0, 1'b1, fa);
    sv[0] = ds_link_model_i.regs[0];
    sv[1] = ds_link_model_i.regs[1];
    pulse_rd(1'b1, 4'h2);
    cap(32);
    chk_frame(0, 1'b1, fa, sv[0]);
    chk_frame(16, 1'b1, fa, sv[1]);
    idle(per);
    // Stop command in mid-frame
    cfg(1'b1, 3'h0, 1'b0, 4'h0);
    pulse_rd(1'b1, 4'h4);
    cap(6);
    bus(1'b1, 32'(CMD_OFS), 32'h1);
    repeat (2) @(negedge hclk);
    idle(2000);
    bus(1'b0, 32'(STAT_OFS), 32'h0);
    `CHK(q[2:0], 3'h0)
    run <= 1'b0;
    // Data time-out, flag cleared by reading
    bus(1'b0, 32'(DIAG_OFS), 32'h0);
    stb_try(1'b1, 1'b1);
    n = 0;
    while (out_kill !== 1'b1)
    begin
      @(negedge hclk);
      n++;
      if (n > TMO + 50)
        fail_wait();
    end
    `CHK(n >= TMO - 4, 1'b1)
    bus(1'b0, 32'(DIAG_OFS), 32'h0);
    `CHK(q[0], 1'b1)
    bus(1'b0, 32'(DIAG_OFS), 32'h0);
    `CHK(q[0], 1'b0)
    tally_and_finish();
  end
endmodule
